// >>> logic/bwcr_params.svh
// Constants for the bridge window configuration register bank.
// Included by the package, bwcr_regs and the bench; holds definitions only.
`ifndef BWCR_PARAMS_SVH
`define BWCR_PARAMS_SVH

// Configuration byte offsets, dword aligned
`define BWCR_OFS_MEM_TOP      8'h20
`define BWCR_OFS_PREF_WIN     8'h24
`define BWCR_OFS_PREF_BOT_HI  8'h28
`define BWCR_OFS_PREF_TOP_HI  8'h2C
`define BWCR_OFS_IO_HI        8'h30
`define BWCR_OFS_CAP_PTR      8'h34
`define BWCR_OFS_IRQ          8'h3C

// Writable bit masks per dword
`define BWCR_WM_MEM_TOP       32'hFFF0_0000
`define BWCR_WM_PREF_WIN      32'hFFF0_FFF0
`define BWCR_WM_FULL          32'hFFFF_FFFF
`define BWCR_WM_IRQ           32'h0000_00FF

// Reset values per dword
`define BWCR_RST_ZERO         32'h0000_0000
`define BWCR_RST_PREF_WIN     32'h0001_0001

// Field positions
`define BWCR_MEM_TOP_RNG      31:20
`define BWCR_MEM_NIB_RNG      19:16
`define BWCR_PREF_BOT_RNG     15:4
`define BWCR_PREF_BOT_CAP     3:0
`define BWCR_PREF_TOP_RNG     31:20
`define BWCR_PREF_TOP_CAP     19:16
`define BWCR_IO_BOT_HI_RNG    15:0
`define BWCR_IO_TOP_HI_RNG    31:16
`define BWCR_IRQ_LINE_RNG     7:0
`define BWCR_IRQ_PIN_RNG      15:8
`define BWCR_CAP_PTR_RNG      7:0

// Fixed values and implicit address fill
`define BWCR_CAP_PTR_VAL      8'hDC
`define BWCR_IRQ_PIN_NONE     8'h00
`define BWCR_ADDR64_CODE      4'h1
`define BWCR_MEM_LOW_ZERO     20'h0_0000
`define BWCR_MEM_LOW_ONES     20'hF_FFFF
`define BWCR_IO_LOW_ZERO      12'h000
`define BWCR_IO_LOW_ONES      12'hFFF
`define BWCR_HI_ZERO          32'h0000_0000
`define BWCR_NUM_WORDS        6

`endif

// >>> logic/bwcr_pkg.sv
// Types shared by the bridge window configuration register bank.
// Assumes bwcr_params.svh is on the include path.
`include "bwcr_params.svh"

package bwcr_pkg;

    // Configuration access from the host side
    typedef struct packed {
        logic        sel;
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } bwcr_cfg_req_t;

    // Configuration answer, one cycle after the access
    typedef struct packed {
        logic        ack;
        logic        hit;
        logic [31:0] rdata;
    } bwcr_cfg_rsp_t;

    // Window fields kept by neighbouring register blocks
    typedef struct packed {
        logic [11:0] mem_bottom;
        logic [3:0]  io_bottom_nib;
        logic [3:0]  io_top_nib;
    } bwcr_ext_win_t;

    // Address to be checked against the windows
    typedef struct packed {
        logic        valid;
        logic        is_io;
        logic [63:0] addr;
    } bwcr_fwd_req_t;

    // Forwarding decision
    typedef struct packed {
        logic        valid;
        logic        mem_hit;
        logic        pref_hit;
        logic        io_hit;
    } bwcr_fwd_rsp_t;

endpackage : bwcr_pkg

// >>> logic/bwcr_word_reg.sv
// One configuration dword with a per-bit writable mask.
// Bits outside the mask hold their reset value forever.
`timescale 1ns/10ps

module bwcr_word_reg #(
    parameter logic [31:0] P_RST   = 32'h0000_0000,
    parameter logic [31:0] P_WMASK = 32'hFFFF_FFFF
) (
    // Clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_rstn,
    // Write port
    input  wire logic        i_we,
    input  wire logic [3:0]  i_be,
    input  wire logic [31:0] i_wd,
    // Stored value
    output logic      [31:0] o_q
);

    logic [31:0] word_q;
    logic [31:0] word_d;
    wire  [31:0] lane_m;

    // Byte enables widened to bits, then limited to writable bits
    assign lane_m = {{8{i_be[3]}}, {8{i_be[2]}}, {8{i_be[1]}}, {8{i_be[0]}}} & P_WMASK;
    assign word_d = i_we ? ((word_q & ~lane_m) | (i_wd & lane_m)) : word_q;
    assign o_q    = word_q;

    // Storage
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            word_q <= P_RST;
        end else begin
            word_q <= word_d;
        end
    end

endmodule // bwcr_word_reg

// >>> logic/bwcr_window_cmp.sv
// Inclusive address range check: bottom <= addr <= top.
// Purely combinational; the caller registers the result.
`timescale 1ns/10ps

module bwcr_window_cmp #(
    parameter int P_W = 64
) (
    // Operands
    input  wire logic [P_W-1:0] i_addr,
    input  wire logic [P_W-1:0] i_bottom,
    input  wire logic [P_W-1:0] i_top,
    // Result
    output logic                o_hit
);

    // An inverted window (top below bottom) never hits
    assign o_hit = (i_addr >= i_bottom) && (i_addr <= i_top);

endmodule // bwcr_window_cmp

// >>> logic/bwcr_regs.sv
// Bridge window configuration registers and the forwarding decision they steer.
// Assumes a configuration access port with one access per cycle and synchronous inputs;
// the memory bottom and I/O low nibbles come from neighbouring register blocks.
`timescale 1ns/10ps
`include "bwcr_params.svh"

module bwcr_regs (
    // Clock and reset
    input  wire logic                   i_clk_sys,
    input  wire logic                   i_rstn,
    // Configuration access
    input  wire bwcr_pkg::bwcr_cfg_req_t i_cfg_req,
    output bwcr_pkg::bwcr_cfg_rsp_t      o_cfg_rsp,
    // Neighbouring window fields
    input  wire bwcr_pkg::bwcr_ext_win_t i_ext_win,
    // Forwarding check
    input  wire bwcr_pkg::bwcr_fwd_req_t i_fwd_req,
    output bwcr_pkg::bwcr_fwd_rsp_t      o_fwd_rsp
);

    // Word table: offsets, writable masks and reset values in one place
    localparam logic [7:0]  WORD_OFS [`BWCR_NUM_WORDS] = '{
        `BWCR_OFS_MEM_TOP, `BWCR_OFS_PREF_WIN, `BWCR_OFS_PREF_BOT_HI,
        `BWCR_OFS_PREF_TOP_HI, `BWCR_OFS_IO_HI, `BWCR_OFS_IRQ};
    localparam logic [31:0] WORD_WM  [`BWCR_NUM_WORDS] = '{
        `BWCR_WM_MEM_TOP, `BWCR_WM_PREF_WIN, `BWCR_WM_FULL,
        `BWCR_WM_FULL, `BWCR_WM_FULL, `BWCR_WM_IRQ};
    localparam logic [31:0] WORD_RST [`BWCR_NUM_WORDS] = '{
        `BWCR_RST_ZERO, `BWCR_RST_PREF_WIN, `BWCR_RST_ZERO,
        `BWCR_RST_ZERO, `BWCR_RST_ZERO, `BWCR_RST_ZERO};

    // Word indices into the table
    localparam int W_MEM  = 0;
    localparam int W_PREF = 1;
    localparam int W_PBHI = 2;
    localparam int W_PTHI = 3;
    localparam int W_IOHI = 4;
    localparam int W_IRQ  = 5;

    logic [31:0]            word_q [`BWCR_NUM_WORDS];
    wire  [`BWCR_NUM_WORDS-1:0] word_sel;
    wire                    cfg_go;
    wire                    cfg_wr_go;
    wire                    cap_sel;
    wire                    any_hit;
    wire  [31:0]            rd_mux;
    wire  [31:0]            cap_word;
    bwcr_pkg::bwcr_cfg_rsp_t cfg_rsp_q;
    bwcr_pkg::bwcr_cfg_rsp_t cfg_rsp_d;

    // Access qualification; a read and write together return the old value
    assign cfg_go    = i_cfg_req.sel & (i_cfg_req.wr | i_cfg_req.rd);
    assign cfg_wr_go = i_cfg_req.sel & i_cfg_req.wr;
    assign cap_sel   = (i_cfg_req.addr == `BWCR_OFS_CAP_PTR);

    // Storage words; read-only fields sit outside the writable mask
    for (genvar k = 0; k < `BWCR_NUM_WORDS; k++) begin : g_word
        assign word_sel[k] = (i_cfg_req.addr == WORD_OFS[k]);
        bwcr_word_reg #(
            .P_RST   (WORD_RST[k]),
            .P_WMASK (WORD_WM[k])
        ) u_word (
            .i_clk_sys (i_clk_sys),
            .i_rstn    (i_rstn),
            .i_we      (cfg_wr_go & word_sel[k]),
            .i_be      (i_cfg_req.be),
            .i_wd      (i_cfg_req.wdata),
            .o_q       (word_q[k])
        );
    end

    // Capability pointer is a constant; writes to it have no effect
    assign cap_word = {24'h00_0000, `BWCR_CAP_PTR_VAL};

    // Read selection; unheld lanes read zero so neighbours can be ORed in
    assign any_hit = (|word_sel) | cap_sel;
    assign rd_mux  = word_sel[W_MEM]  ? word_q[W_MEM]  :
                     word_sel[W_PREF] ? word_q[W_PREF] :
                     word_sel[W_PBHI] ? word_q[W_PBHI] :
                     word_sel[W_PTHI] ? word_q[W_PTHI] :
                     word_sel[W_IOHI] ? word_q[W_IOHI] :
                     word_sel[W_IRQ]  ? word_q[W_IRQ]  :
                     cap_sel          ? cap_word       :
                                        32'h0000_0000;

    // Answer builds one cycle after the access; writes without a read return zero data
    assign cfg_rsp_d.ack   = cfg_go;
    assign cfg_rsp_d.hit   = cfg_go & any_hit;
    assign cfg_rsp_d.rdata = (cfg_go & i_cfg_req.rd) ? rd_mux : 32'h0000_0000;

    // Configuration answer register
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            cfg_rsp_q <= '0;
        end else begin
            cfg_rsp_q <= cfg_rsp_d;
        end
    end
    assign o_cfg_rsp = cfg_rsp_q;

    // Window bounds; low address bits are implied, never stored
    wire [63:0] mem_bottom;
    wire [63:0] mem_top;
    wire [63:0] pref_bottom;
    wire [63:0] pref_top;
    wire [63:0] io_bottom;
    wire [63:0] io_top;

    assign mem_bottom  = {`BWCR_HI_ZERO, i_ext_win.mem_bottom, `BWCR_MEM_LOW_ZERO};
    assign mem_top     = {`BWCR_HI_ZERO, word_q[W_MEM][`BWCR_MEM_TOP_RNG], `BWCR_MEM_LOW_ONES};
    assign pref_bottom = {word_q[W_PBHI], word_q[W_PREF][`BWCR_PREF_BOT_RNG], `BWCR_MEM_LOW_ZERO};
    assign pref_top    = {word_q[W_PTHI], word_q[W_PREF][`BWCR_PREF_TOP_RNG], `BWCR_MEM_LOW_ONES};
    assign io_bottom   = {`BWCR_HI_ZERO, word_q[W_IOHI][`BWCR_IO_BOT_HI_RNG], i_ext_win.io_bottom_nib,
                          `BWCR_IO_LOW_ZERO};
    assign io_top      = {`BWCR_HI_ZERO, word_q[W_IOHI][`BWCR_IO_TOP_HI_RNG], i_ext_win.io_top_nib,
                          `BWCR_IO_LOW_ONES};

    wire mem_in;
    wire pref_in;
    wire io_in;

    // Non-prefetchable memory window; 64-bit addresses above 4G miss
    bwcr_window_cmp #(.P_W(64)) u_cmp_mem (
        .i_addr   (i_fwd_req.addr),
        .i_bottom (mem_bottom),
        .i_top    (mem_top),
        .o_hit    (mem_in)
    );

    // Prefetchable window over the full 64-bit address
    bwcr_window_cmp #(.P_W(64)) u_cmp_pref (
        .i_addr   (i_fwd_req.addr),
        .i_bottom (pref_bottom),
        .i_top    (pref_top),
        .o_hit    (pref_in)
    );

    // I/O window, 32-bit I/O space only
    bwcr_window_cmp #(.P_W(64)) u_cmp_io (
        .i_addr   (i_fwd_req.addr),
        .i_bottom (io_bottom),
        .i_top    (io_top),
        .o_hit    (io_in)
    );

    bwcr_pkg::bwcr_fwd_rsp_t fwd_rsp_q;
    bwcr_pkg::bwcr_fwd_rsp_t fwd_rsp_d;

    // Decision by transaction space; an idle cycle shows no hit
    assign fwd_rsp_d.valid    = i_fwd_req.valid;
    assign fwd_rsp_d.mem_hit  = i_fwd_req.valid & ~i_fwd_req.is_io & mem_in;
    assign fwd_rsp_d.pref_hit = i_fwd_req.valid & ~i_fwd_req.is_io & pref_in;
    assign fwd_rsp_d.io_hit   = i_fwd_req.valid & i_fwd_req.is_io & io_in;

    // Forwarding decision register, one cycle after the request
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            fwd_rsp_q <= '0;
        end else begin
            fwd_rsp_q <= fwd_rsp_d;
        end
    end
    assign o_fwd_rsp = fwd_rsp_q;

    // Checks on the configuration side
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rstn);

    wire rd_go = i_cfg_req.sel & i_cfg_req.rd;

    a_memtop_low_zero: assert property (
        rd_go && word_sel[W_MEM] |=> o_cfg_rsp.rdata[`BWCR_MEM_NIB_RNG] == 4'h0 && o_cfg_rsp.ack)
        else $error("memory top low nibble not zero");

    a_memtop_ro: assert property (
        cfg_wr_go && word_sel[W_MEM] |=> word_q[W_MEM][`BWCR_MEM_NIB_RNG] == 4'h0)
        else $error("memory top low nibble took a write");

    // Write, one quiet cycle, then read back; a host rarely reads back to back
    a_memtop_write: assert property (
        cfg_wr_go && word_sel[W_MEM] && i_cfg_req.be[3] && i_cfg_req.be[2] && !i_cfg_req.rd
        ##1 !cfg_wr_go ##1 rd_go && word_sel[W_MEM] && !i_cfg_req.wr
        |=> o_cfg_rsp.rdata[`BWCR_MEM_TOP_RNG] == $past(i_cfg_req.wdata[`BWCR_MEM_TOP_RNG], 3))
        else $error("memory top field lost a write");

    a_pref_codes: assert property (
        word_q[W_PREF][`BWCR_PREF_BOT_CAP] == `BWCR_ADDR64_CODE &&
        word_q[W_PREF][`BWCR_PREF_TOP_CAP] == `BWCR_ADDR64_CODE)
        else $error("prefetch addressing code changed");

    a_pref_codes_rd: assert property (
        rd_go && word_sel[W_PREF]
        |=> o_cfg_rsp.rdata[`BWCR_PREF_BOT_CAP] == `BWCR_ADDR64_CODE &&
            o_cfg_rsp.rdata[`BWCR_PREF_TOP_CAP] == `BWCR_ADDR64_CODE)
        else $error("prefetch addressing code read wrong");

    a_pref_bot_write: assert property (
        cfg_wr_go && word_sel[W_PREF] && i_cfg_req.be[1] && i_cfg_req.be[0]
        |=> pref_bottom[31:20] == $past(i_cfg_req.wdata[`BWCR_PREF_BOT_RNG]) &&
            pref_bottom[19:0] == `BWCR_MEM_LOW_ZERO)
        else $error("prefetch bottom field wrong");

    a_pref_top_write: assert property (
        cfg_wr_go && word_sel[W_PREF] && i_cfg_req.be[3] && i_cfg_req.be[2]
        |=> pref_top[31:20] == $past(i_cfg_req.wdata[`BWCR_PREF_TOP_RNG]) &&
            pref_top[19:0] == `BWCR_MEM_LOW_ONES)
        else $error("prefetch top field wrong");

    a_pref_hi_words: assert property (
        cfg_wr_go && word_sel[W_PBHI] && i_cfg_req.be == 4'hF
        |=> word_q[W_PBHI] == $past(i_cfg_req.wdata) && pref_bottom[63:32] == word_q[W_PBHI])
        else $error("prefetch bottom high word missed a write");

    a_pref_top_hi: assert property (
        cfg_wr_go && word_sel[W_PTHI] && i_cfg_req.be == 4'hF
        |=> word_q[W_PTHI] == $past(i_cfg_req.wdata) && pref_top[63:32] == word_q[W_PTHI])
        else $error("prefetch top high word missed a write");

    a_lane_keep: assert property (
        cfg_wr_go && word_sel[W_PBHI] && !i_cfg_req.be[0]
        |=> word_q[W_PBHI][7:0] == $past(word_q[W_PBHI][7:0]))
        else $error("disabled byte lane changed");

    a_rdwr_old: assert property (
        rd_go && cfg_wr_go && word_sel[W_PBHI] |=> o_cfg_rsp.rdata == $past(word_q[W_PBHI]))
        else $error("read with write did not return the old value");

    a_io_halves: assert property (
        cfg_wr_go && word_sel[W_IOHI] && i_cfg_req.be == 4'hF
        |=> io_bottom[31:16] == $past(i_cfg_req.wdata[`BWCR_IO_BOT_HI_RNG]) &&
            io_top[31:16] == $past(i_cfg_req.wdata[`BWCR_IO_TOP_HI_RNG]))
        else $error("I/O high halves missed a write");

    a_cap_pointer: assert property (
        rd_go && cap_sel |=> o_cfg_rsp.rdata == {24'h00_0000, `BWCR_CAP_PTR_VAL} && o_cfg_rsp.hit)
        else $error("capability pointer wrong");

    a_irq_pin_none: assert property (
        rd_go && word_sel[W_IRQ] |=> o_cfg_rsp.rdata[`BWCR_IRQ_PIN_RNG] == `BWCR_IRQ_PIN_NONE)
        else $error("interrupt pin byte not zero");

    a_irq_pin_ro: assert property (
        cfg_wr_go && word_sel[W_IRQ] |=> word_q[W_IRQ][`BWCR_IRQ_PIN_RNG] == `BWCR_IRQ_PIN_NONE)
        else $error("interrupt pin byte took a write");

    a_irq_line_keep: assert property (
        cfg_wr_go && word_sel[W_IRQ] && i_cfg_req.be[0]
        |=> word_q[W_IRQ][`BWCR_IRQ_LINE_RNG] == $past(i_cfg_req.wdata[`BWCR_IRQ_LINE_RNG]) &&
            word_q[W_IRQ][31:8] == 24'h00_0000)
        else $error("interrupt byte write wrong");

    a_unmapped_zero: assert property (
        cfg_go && !any_hit |=> o_cfg_rsp.ack && !o_cfg_rsp.hit && o_cfg_rsp.rdata == 32'h0000_0000)
        else $error("unmapped access answered with data");

    // Answer stands one cycle per access; writes without a read carry no data back
    a_cfg_ack: assert property (
        cfg_go |=> o_cfg_rsp.ack)
        else $error("access not acknowledged");

    a_cfg_idle: assert property (
        !cfg_go |=> !o_cfg_rsp.ack && !o_cfg_rsp.hit && o_cfg_rsp.rdata == 32'h0000_0000)
        else $error("answer shown without access");

    a_write_no_data: assert property (
        cfg_wr_go && !i_cfg_req.rd |=> o_cfg_rsp.rdata == 32'h0000_0000)
        else $error("write answered with data");

    // Checks on the forwarding side
    a_fwd_valid: assert property (
        i_fwd_req.valid |=> o_fwd_rsp.valid)
        else $error("request without decision");

    a_mem_hit: assert property (
        i_fwd_req.valid && !i_fwd_req.is_io && i_fwd_req.addr[63:32] == 32'h0000_0000 &&
        i_fwd_req.addr[31:20] >= i_ext_win.mem_bottom &&
        i_fwd_req.addr[31:20] <= word_q[W_MEM][`BWCR_MEM_TOP_RNG]
        |=> o_fwd_rsp.mem_hit && !o_fwd_rsp.io_hit)
        else $error("memory window hit missed");

    a_mem_above_4g: assert property (
        i_fwd_req.valid && i_fwd_req.addr[63:32] != 32'h0000_0000 |=> !o_fwd_rsp.mem_hit)
        else $error("memory window hit above 4G");

    a_pref_miss_hi: assert property (
        i_fwd_req.valid && !i_fwd_req.is_io && i_fwd_req.addr[63:32] > word_q[W_PTHI]
        |=> !o_fwd_rsp.pref_hit)
        else $error("prefetch hit above 64-bit top");

    a_pref_miss_lo: assert property (
        i_fwd_req.valid && i_fwd_req.addr[63:32] < word_q[W_PBHI] |=> !o_fwd_rsp.pref_hit)
        else $error("prefetch hit below 64-bit bottom");

    a_space_split: assert property (
        i_fwd_req.valid && i_fwd_req.is_io |=> !o_fwd_rsp.mem_hit && !o_fwd_rsp.pref_hit)
        else $error("memory hit on an I/O request");

    a_io_bot_edge: assert property (
        i_fwd_req.valid && i_fwd_req.is_io && io_bottom <= io_top &&
        i_fwd_req.addr == {32'h0000_0000, word_q[W_IOHI][`BWCR_IO_BOT_HI_RNG], i_ext_win.io_bottom_nib,
                           `BWCR_IO_LOW_ZERO}
        |=> o_fwd_rsp.io_hit && !o_fwd_rsp.mem_hit)
        else $error("I/O bottom address not forwarded");

    a_io_top_edge: assert property (
        i_fwd_req.valid && i_fwd_req.is_io &&
        i_fwd_req.addr == {32'h0000_0000, word_q[W_IOHI][`BWCR_IO_TOP_HI_RNG], i_ext_win.io_top_nib,
                           `BWCR_IO_LOW_ONES} && io_bottom <= io_top
        |=> o_fwd_rsp.io_hit && !o_fwd_rsp.mem_hit)
        else $error("I/O top address not forwarded");

    a_io_top_miss: assert property (
        i_fwd_req.valid && i_fwd_req.is_io && i_fwd_req.addr == io_top + 64'd1
        |=> !o_fwd_rsp.io_hit)
        else $error("I/O address above top forwarded");

    a_fwd_idle: assert property (
        !i_fwd_req.valid |=> !o_fwd_rsp.valid && !o_fwd_rsp.mem_hit && !o_fwd_rsp.pref_hit && !o_fwd_rsp.io_hit)
        else $error("decision shown without request");

    // Main scenarios
    c_mem_hit:   cover property (o_fwd_rsp.mem_hit);
    c_pref_hit:  cover property (o_fwd_rsp.pref_hit && pref_top[63:32] != 32'h0000_0000);
    c_io_hit:    cover property (o_fwd_rsp.io_hit);
    c_cap_read:  cover property (rd_go && cap_sel ##1 o_cfg_rsp.ack);
    c_rdwr_old:  cover property (rd_go && cfg_wr_go ##1 o_cfg_rsp.ack);

endmodule // bwcr_regs

// >>> tb/bwcr_regs_tb_top.sv
// Self-checking bench for the bridge window configuration register bank.
// Assumes bwcr_pkg is compiled first and bwcr_params.svh is on the include path.
`timescale 1ns/10ps
`include "bwcr_params.svh"

module bwcr_regs_tb_top;

    logic                    i_clk_sys;
    logic                    i_rstn;
    bwcr_pkg::bwcr_cfg_req_t req;
    bwcr_pkg::bwcr_cfg_rsp_t rsp;
    bwcr_pkg::bwcr_ext_win_t ext;
    bwcr_pkg::bwcr_fwd_req_t freq;
    bwcr_pkg::bwcr_fwd_rsp_t frsp;
    int                      err_total;
    int                      tests_run;
    logic [31:0]             mdl [0:255];
    logic [7:0]              ofs_list [0:8] = '{8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h3C, 8'h38, 8'h04};

    bwcr_regs i_bwcr_regs (
        .i_clk_sys (i_clk_sys),
        .i_rstn    (i_rstn),
        .i_cfg_req (req),
        .o_cfg_rsp (rsp),
        .i_ext_win (ext),
        .i_fwd_req (freq),
        .o_fwd_rsp (frsp)
    );

    // 25 MHz system clock
    initial begin
        i_clk_sys = 1'b0;
        forever #20 i_clk_sys = ~i_clk_sys;
    end

    // Writable bits per dword; zero mask also covers unmapped offsets
    function automatic logic [31:0] wmask(input logic [7:0] a);
        case (a)
            `BWCR_OFS_MEM_TOP: wmask = `BWCR_WM_MEM_TOP;
            `BWCR_OFS_PREF_WIN: wmask = `BWCR_WM_PREF_WIN;
            `BWCR_OFS_PREF_BOT_HI, `BWCR_OFS_PREF_TOP_HI, `BWCR_OFS_IO_HI: wmask = `BWCR_WM_FULL;
            `BWCR_OFS_IRQ: wmask = `BWCR_WM_IRQ;
            default: wmask = 32'h0000_0000;
        endcase
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = a inside {8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h3C};
    endfunction

    // Window bottoms and tops: 0 memory, 1 prefetchable, 2 I/O
    function automatic logic [63:0] win_lo(input int k);
        case (k)
            0: win_lo = {32'h0000_0000, ext.mem_bottom, 20'h0_0000};
            1: win_lo = {mdl[`BWCR_OFS_PREF_BOT_HI], mdl[`BWCR_OFS_PREF_WIN][15:4], 20'h0_0000};
            default: win_lo = {32'h0000_0000, mdl[`BWCR_OFS_IO_HI][15:0], ext.io_bottom_nib, 12'h000};
        endcase
    endfunction

    function automatic logic [63:0] win_hi(input int k);
        case (k)
            0: win_hi = {32'h0000_0000, mdl[`BWCR_OFS_MEM_TOP][31:20], 20'hF_FFFF};
            1: win_hi = {mdl[`BWCR_OFS_PREF_TOP_HI], mdl[`BWCR_OFS_PREF_WIN][31:20], 20'hF_FFFF};
            default: win_hi = {32'h0000_0000, mdl[`BWCR_OFS_IO_HI][31:16], ext.io_top_nib, 12'hFFF};
        endcase
    endfunction

    // Inclusive range; an inverted window never matches
    function automatic logic in_win(input int k, input logic [63:0] a);
        in_win = (a >= win_lo(k)) && (a <= win_hi(k));
    endfunction

    task automatic model_reset();
        for (int i = 0; i < 256; i++) mdl[i] = 32'h0000_0000;
        mdl[`BWCR_OFS_PREF_WIN] = `BWCR_RST_PREF_WIN;
        mdl[`BWCR_OFS_CAP_PTR]  = {24'h00_0000, `BWCR_CAP_PTR_VAL};
    endtask

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string msg);
        tests_run++;
        if (seen !== exp) begin
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
            err_total++;
        end
    endtask

    task automatic print_verdict();
        if (err_total == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // One access; answer comes exactly one edge after it is taken
    task automatic cfg(input logic w, input logic r, input logic [7:0] a, input logic [3:0] be,
                       input logic [31:0] wd);
        logic [31:0] old;
        logic [31:0] m;
        old = mdl[a];
        m   = wmask(a) & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        @(posedge i_clk_sys);
        req <= '{sel: 1'b1, wr: w, rd: r, addr: a, be: be, wdata: wd};
        @(posedge i_clk_sys);
        req <= '0;
        if (w) mdl[a] = (old & ~m) | (wd & m);
        #1;
        chk(rsp.ack, 1'b1, "config ack");
        chk(rsp.hit, mapped(a), "config hit");
        chk(rsp.rdata, r ? old : 32'h0000_0000, "config read data");
    endtask

    // One forwarding lookup against the register values of the edge
    task automatic fwd(input logic io, input logic [63:0] a);
        @(posedge i_clk_sys);
        freq <= '{valid: 1'b1, is_io: io, addr: a};
        @(posedge i_clk_sys);
        freq <= '0;
        #1;
        chk(frsp.valid, 1'b1, "forward valid");
        chk(frsp.mem_hit, !io && in_win(0, a), "memory hit");
        chk(frsp.pref_hit, !io && in_win(1, a), "prefetch hit");
        chk(frsp.io_hit, io && in_win(2, a), "io hit");
    endtask

    // Hang guard
    initial begin
        repeat (60000) @(posedge i_clk_sys);
        err_total++;
        print_verdict();
    end

    // Main sequence: reset values, masks, random lanes, window corners, second reset
    initial begin
        logic [11:0] x;
        logic [11:0] y;
        logic [11:0] t;
        logic [63:0] e;
        int          k;
        i_rstn    = 1'b0;
        req       = '0;
        freq      = '0;
        ext       = '0;
        err_total = 0;
        tests_run = 0;
        model_reset();
        void'($urandom(13239));
        repeat (20) @(posedge i_clk_sys);
        i_rstn <= 1'b1;
        foreach (ofs_list[i]) cfg(1'b0, 1'b1, ofs_list[i], 4'hF, 32'h0000_0000);
        // All ones then all zeros; all ones also programs the line byte to FF
        for (int p = 0; p < 2; p++) begin
            foreach (ofs_list[i]) cfg(1'b1, 1'b0, ofs_list[i], 4'hF, p ? 32'h0000_0000 : 32'hFFFF_FFFF);
            foreach (ofs_list[i]) cfg(1'b0, 1'b1, ofs_list[i], 4'hF, 32'h0000_0000);
        end
        // Random lanes, some with read and write together
        repeat (40) begin
            k = $urandom % 9;
            cfg(1'b1, 1'($urandom), ofs_list[k], 4'($urandom), $urandom);
            cfg(1'b0, 1'b1, ofs_list[k], 4'hF, 32'h0000_0000);
        end
        // Window rounds; the last one leaves its prefetchable window inverted and the others unsorted
        for (int r = 0; r < 6; r++) begin
            x = 12'($urandom);
            y = 12'($urandom);
            if (r < 5 && x > y) begin
                t = x;
                x = y;
                y = t;
            end
            @(posedge i_clk_sys);
            ext <= '{mem_bottom: x, io_bottom_nib: 4'($urandom), io_top_nib: 4'($urandom)};
            cfg(1'b1, 1'b0, `BWCR_OFS_MEM_TOP, 4'hF, {y, 20'h0_0000});
            cfg(1'b0, 1'b1, `BWCR_OFS_MEM_TOP, 4'hF, 32'h0000_0000);
            cfg(1'b1, 1'b0, `BWCR_OFS_PREF_WIN, 4'hF, {y, 4'h0, x, 4'h0});
            cfg(1'b1, 1'b0, `BWCR_OFS_PREF_BOT_HI, 4'hF, 32'(r % 2));
            cfg(1'b1, 1'b0, `BWCR_OFS_PREF_TOP_HI, 4'hF, (r == 5) ? 32'h0000_0000 : 32'h0000_0001);
            cfg(1'b1, 1'b0, `BWCR_OFS_IO_HI, 4'hF, {y, y[3:0], x, x[3:0]});
            repeat (12) begin
                k = $urandom % 3;
                e = ($urandom % 2) ? win_hi(k) : win_lo(k);
                e = e + 64'($urandom % 3) - 64'd1;
                fwd(k == 2, e);
            end
            fwd(1'($urandom), {$urandom, $urandom});
        end
        // Second reset in mid-run
        @(posedge i_clk_sys);
        i_rstn <= 1'b0;
        repeat (3) @(posedge i_clk_sys);
        #1;
        chk(rsp.ack, 1'b0, "ack in reset");
        chk(frsp.valid, 1'b0, "forward valid in reset");
        @(posedge i_clk_sys);
        i_rstn <= 1'b1;
        model_reset();
        foreach (ofs_list[i]) cfg(1'b0, 1'b1, ofs_list[i], 4'hF, 32'h0000_0000);
        print_verdict();
    end

endmodule // bwcr_regs_tb_top
